// ### rtl/sere_dev.sv
// eeprom engine: two-wire target, page buffer, array and write-cycle timer
// How it works
// - device word: type, select bits, direction
// - 4K uses low select as address msb
// - ack each byte low on ninth clock
// - write sends word address, acked before data
// - controller stops after last write byte
// - stop starts self-timed write, inputs ignored
// - write cycle ends within 5 ms
// - page of 8 or 16 bytes
// - page write sends up to 7/15 more
// - every page write byte is acked
// - write bumps only low page bits
// - extra page bytes wrap and overwrite
// - polling acked only after write finishes
// - read starts like write, direction one
// - address counter holds last plus one
// - read counter wraps end to start
// - current read shifts out counter byte
// - random read: dummy write, repeated start
// - controller ack fetches next byte
// - controller nack then stop ends read
`timescale 1ns/100ps
module sere_dev
  import sere_pkg::*;
#(
  parameter bit BIG       = 1'b0,    // 0: 2K, 1: 4K
  parameter int WR_CYCLES = WR_CYC   // clocks of one self-timed write
) (
  input  logic     clock,
  input  logic     rstn,
  sere_link_if.dev link,
  input  logic     select_pin_high,
  input  logic     select_pin_mid,
  input  logic     select_pin_low,
  output logic     write_busy
);
  // density shapes address, page and compare widths
  localparam int AW = BIG ? 9 : 8;
  localparam int PW = BIG ? 4 : 3;
  localparam int NB = 1 << PW;
  localparam int MB = 1 << AW;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TACK} sere_dst_t;
  typedef enum logic [1:0] {K_DEV, K_ADDR, K_DATA} sere_kind_t;

  // link domain
  sere_dst_t     st_q;
  sere_kind_t    kind_q;
  logic [2:0]    cnt_q;
  logic [7:0]    sh_q;
  logic [7:0]    tx_q;
  logic [AW-1:0] addr_q;
  logic [7:0]    pbuf_q [NB];
  logic [NB-1:0] pmask_q;
  logic          rd_q, msb_q, arm_q, oe_q;
  logic          start_tog_q, start_seen_q, busy_s;
  logic [2:0]    sel_s;
  // core clock domain
  logic [7:0]    mem_q [MB];
  logic [17:0]   tmr_q;
  logic          busy_q, arm_s, scl_s, sda_s, scl_p_q, sda_p_q;
  // decode
  logic          start_pend, byte_done, dev_hit, stop_ev, commit;
  logic [7:0]    rd_byte;
  logic [PW-1:0] lo;

  assign start_pend = start_tog_q != start_seen_q;
  assign byte_done  = !start_pend && st_q == ST_RX && cnt_q == 3'd7;
  assign lo         = addr_q[PW-1:0];
  assign rd_byte    = mem_q[addr_q];
  // device word compare; 4K leaves the low select bit to the address
  assign dev_hit    = sh_q[7:4] == DEV_TYPE && !busy_s &&
                      (BIG ? sh_q[3:2] == sel_s[2:1] : sh_q[3:1] == sel_s);

  // busy level and select straps into the link domain
  sere_sync #(.W(4)) u_lsync (
    .clock (link.scl),
    .rstn  (rstn),
    .d     ({busy_q, select_pin_high, select_pin_mid, select_pin_low}),
    .q     ({busy_s, sel_s})
  );

  // start: data falls while clock high
  always_ff @(negedge link.sda or negedge rstn) begin
    if (!rstn) begin
      start_tog_q <= 1'b0;
    end else if (link.scl) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // bits are taken on the rising clock
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      sh_q <= '0;
    end else begin
      sh_q <= {sh_q[6:0], link.sda};
    end
  end

  // page buffer; index wraps inside the page
  always_ff @(negedge link.scl or negedge rstn) begin
    if (!rstn) begin
      pmask_q <= '0;
      for (int i = 0; i < NB; i++) begin
        pbuf_q[i] <= '0;
      end
    end else if (byte_done && kind_q == K_ADDR) begin
      pmask_q <= '0;
    end else if (byte_done && kind_q == K_DATA) begin
      pbuf_q[lo]  <= sh_q;
      pmask_q[lo] <= 1'b1;
    end
  end

  // protocol sequencer; output changes on the falling clock
  always_ff @(negedge link.scl or negedge rstn) begin
    if (!rstn) begin
      st_q         <= ST_IDLE;
      kind_q       <= K_DEV;
      cnt_q        <= '0;
      oe_q         <= 1'b0;
      rd_q         <= 1'b0;
      msb_q        <= 1'b0;
      arm_q        <= 1'b0;
      addr_q       <= '0;
      tx_q         <= '0;
      start_seen_q <= 1'b0;
    end else if (start_pend) begin
      start_seen_q <= start_tog_q;
      st_q         <= ST_RX;
      kind_q       <= K_DEV;
      cnt_q        <= '0;
      oe_q         <= 1'b0;
      arm_q        <= 1'b0;
    end else begin
      oe_q <= 1'b0;
      case (st_q)
        ST_RX: begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'd7) begin
            st_q <= ST_ACK;
            oe_q <= 1'b1;
            case (kind_q)
              K_DEV: begin
                rd_q  <= sh_q[RW_BIT];
                msb_q <= sh_q[PAGE_BIT];
                if (!dev_hit) begin
                  st_q <= ST_IDLE;
                  oe_q <= 1'b0;
                end
              end
              K_ADDR: begin
                addr_q <= AW'({msb_q, sh_q});
              end
              default: begin
                addr_q <= {addr_q[AW-1:PW], PW'(lo + 1'b1)};
                arm_q  <= 1'b1;
              end
            endcase
          end
        end
        ST_ACK: begin
          cnt_q <= '0;
          case (kind_q)
            K_DEV: begin
              if (rd_q) begin
                st_q <= ST_TX;
                tx_q <= rd_byte;
                oe_q <= ~rd_byte[7];
              end else begin
                st_q   <= ST_RX;
                kind_q <= K_ADDR;
              end
            end
            K_ADDR: begin
              st_q   <= ST_RX;
              kind_q <= K_DATA;
            end
            default: begin
              st_q <= ST_RX;
            end
          endcase
        end
        ST_TX: begin
          cnt_q <= cnt_q + 3'd1;
          tx_q  <= {tx_q[6:0], 1'b0};
          if (cnt_q == 3'd7) begin
            st_q   <= ST_TACK;
            addr_q <= addr_q + 1'b1;
          end else begin
            oe_q <= ~tx_q[6];
          end
        end
        ST_TACK: begin
          cnt_q <= '0;
          if (!sh_q[0]) begin
            st_q <= ST_TX;
            tx_q <= rd_byte;
            oe_q <= ~rd_byte[7];
          end else begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // pull low only for ack and zero data bits
  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = oe_q;

  // wire levels and armed flag into the core clock
  sere_sync #(.W(3)) u_csync (
    .clock (clock),
    .rstn  (rstn),
    .d     ({arm_q, link.scl, link.sda}),
    .q     ({arm_s, scl_s, sda_s})
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // stop: data rises while clock high; armed only after a data byte
  assign stop_ev = scl_s && scl_p_q && sda_s && !sda_p_q;
  assign commit  = stop_ev && arm_s && !busy_q;

  // self-timed write, shortened by the crossing delay
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      tmr_q  <= '0;
    end else if (commit) begin
      busy_q <= 1'b1;
      tmr_q  <= 18'(WR_CYCLES - SYNC_LAT);
    end else if (busy_q) begin
      if (tmr_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q - 18'd1;
      end
    end
  end

  assign write_busy = busy_q;

  // array: buffered bytes of the addressed page land at the stop
  for (genvar i = 0; i < MB; i++) begin : g_mem
    localparam logic [AW-1:0] IX = AW'(i);
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        mem_q[i] <= ERASED;
      end else if (commit && IX[AW-1:PW] == addr_q[AW-1:PW] && pmask_q[IX[PW-1:0]]) begin
        mem_q[i] <= pbuf_q[IX[PW-1:0]];
      end
    end
  end
endmodule

// ### rtl/sere_host.sv
// two-wire bus controller: start, stop, byte write and byte read
`timescale 1ns/100ps
module sere_host
  import sere_pkg::*;
(
  input  logic       clock,
  input  logic       rstn,
  sere_link_if.host  link,
  input  logic       cmd_valid,
  output logic       cmd_ready,
  input  sere_op_t   cmd_op,
  input  logic [7:0] cmd_data,
  input  logic       cmd_nack,
  output logic       rsp_valid,
  output logic [7:0] rsp_data,
  output logic       rsp_ack
);
  typedef enum logic {H_IDLE, H_RUN} sere_hst_t;

  sere_hst_t  st_q;
  sere_op_t   op_q;
  logic [7:0] sh_q;
  logic [4:0] qc_q;
  logic [1:0] qt_q;
  logic [3:0] bit_q;
  logic       nack_q;
  logic       ack_q;
  logic       rsp_q;
  logic       scl_q;
  logic       rel_q;
  logic       sda_s;
  logic       scl_d;
  logic       rel_d;
  logic       tick;
  logic       last_bit;

  sere_sync #(.W(1)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (link.sda),
    .q     (sda_s)
  );

  assign tick     = st_q == H_RUN && qc_q == 5'(QTR_CYC - 1);
  assign last_bit = op_q == OP_START || op_q == OP_STOP || bit_q == 4'd8;

  // wire levels for each quarter of the current symbol
  always_comb begin
    scl_d = qt_q == 2'd1 || qt_q == 2'd2;
    rel_d = 1'b1;
    case (op_q)
      OP_START: begin
        rel_d = qt_q < 2'd2;
      end
      OP_STOP: begin
        scl_d = qt_q != 2'd0;
        rel_d = qt_q >= 2'd2;
      end
      OP_WRITE: begin
        rel_d = bit_q == 4'd8 || sh_q[7];
      end
      default: begin
        rel_d = bit_q != 4'd8 || nack_q;
      end
    endcase
  end

  // quarter timer divides the core clock into the serial clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      qc_q <= '0;
    end else if (st_q == H_RUN && !tick) begin
      qc_q <= qc_q + 5'd1;
    end else begin
      qc_q <= '0;
    end
  end

  // registered wire drive; bus idles released
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      rel_q <= 1'b1;
    end else if (st_q == H_RUN) begin
      scl_q <= scl_d;
      rel_q <= rel_d;
    end
  end

  // command sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q   <= H_IDLE;
      op_q   <= OP_STOP;
      sh_q   <= '0;
      qt_q   <= '0;
      bit_q  <= '0;
      nack_q <= 1'b1;
      ack_q  <= 1'b0;
      rsp_q  <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (cmd_valid) begin
            st_q   <= H_RUN;
            op_q   <= cmd_op;
            sh_q   <= cmd_data;
            nack_q <= cmd_nack;
            qt_q   <= '0;
            bit_q  <= '0;
          end
        end
        H_RUN: begin
          if (tick) begin
            qt_q <= qt_q + 2'd1;
            // sample in the middle of the high time
            if (qt_q == 2'd1 && op_q == OP_READ && bit_q != 4'd8) begin
              sh_q <= {sh_q[6:0], sda_s};
            end
            if (qt_q == 2'd1 && op_q == OP_WRITE && bit_q == 4'd8) begin
              ack_q <= ~sda_s;
            end
            if (qt_q == 2'd3) begin
              bit_q <= bit_q + 4'd1;
              if (op_q == OP_WRITE) begin
                sh_q <= {sh_q[6:0], 1'b0};
              end
              if (last_bit) begin
                st_q  <= H_IDLE;
                rsp_q <= op_q == OP_WRITE || op_q == OP_READ;
              end
            end
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready        = st_q == H_IDLE;
  assign rsp_valid        = rsp_q;
  assign rsp_data         = sh_q;
  assign rsp_ack          = ack_q;
  assign link.scl         = scl_q;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = ~rel_q;
endmodule

// ### rtl/sere_link_if.sv
// two-wire link between the eeprom engine and its bus controller
`timescale 1ns/100ps
interface sere_link_if;
  logic scl;          // serial clock, made by the controller
  logic sda;          // resolved data line
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;

  // open drain with the pull-up folded in
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));

  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface

// ### rtl/sere_pkg.sv
// shared constants and types for the serial eeprom engine and its controller
package sere_pkg;
  // device-type code in the top nibble of the device word; value is arbitrary
  localparam logic [3:0] DEV_TYPE   = 4'h6;
  localparam int         RW_BIT     = 0;        // direction bit of device word
  localparam int         PAGE_BIT   = 1;        // page_high_address_bit (4K)
  localparam logic [7:0] ERASED     = 8'hff;    // array content after reset
  localparam int         CLK_MHZ    = 40;
  // self-timed write, longest time, rounded down to clocks
  localparam int         WR_TIME_NS = 5000000;
  localparam int         WR_CYC     = WR_TIME_NS * CLK_MHZ / 1000;
  // clocks from stop on the wire to the timer start (synchroniser plus edge)
  localparam int         SYNC_LAT   = 4;
  // controller quarter bit time, least time, rounded up to clocks
  localparam int         QTR_NS     = 625;
  localparam int         QTR_CYC    = (QTR_NS * CLK_MHZ + 999) / 1000;
  // controller commands
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} sere_op_t;
endpackage

// ### rtl/sere_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sere_sync #(
  parameter int W = 1
) (
  input  logic         clock,
  input  logic         rstn,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### verif/sere_props.sv
// link checker: device acknowledge, line release and write-cycle timing
`timescale 1ns/100ps
module sere_props
  import sere_pkg::*;
#(
  parameter int WR_CYCLES = 64
) (
  input logic clock,
  input logic rstn,
  input logic scl,
  input logic sda,
  input logic sda_dev_o,
  input logic sda_dev_oe,
  input logic write_busy,
  input logic select_pin_high,
  input logic select_pin_mid,
  input logic select_pin_low
);
  logic       scl_p;
  logic       sda_p;
  logic       first;
  logic [3:0] rises;
  logic [7:0] word;
  int         busy_n;

  // start detect, bit count and device word capture
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      first <= 1'b0;
      rises <= 4'h0;
      word  <= 8'h00;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      if (scl && scl_p && sda_p && !sda) begin
        first <= 1'b1;
        rises <= 4'h0;
      end else if (scl && !scl_p) begin
        rises <= rises + 4'h1;
        word  <= {word[6:0], sda};
        if (rises == 4'h8) first <= 1'b0;
      end
    end
  end

  // length of the running self-timed write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) busy_n <= 0;
    else busy_n <= write_busy ? busy_n + 1 : 0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_stop;
    scl && $past(scl) && sda && !$past(sda);
  endsequence
  sequence s_word_ack;
    $rose(sda_dev_oe) && first;
  endsequence

  a_ack_on_fall: assert property ($changed(sda_dev_oe) |-> $fell(scl))
    else $error("device data drive changed away from a clock fall");
  a_open_drain: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
    else $error("device drive does not pull the line low");
  a_stop_release: assert property (s_stop |-> !sda_dev_oe [*8])
    else $error("device drives the line after a stop");
  a_busy_at_stop: assert property ($rose(write_busy) |-> scl && sda && !sda_dev_oe)
    else $error("write cycle started without a stop on the link");
  a_busy_quiet: assert property (write_busy |-> !sda_dev_oe)
    else $error("device answers during the write cycle");
  a_busy_max: assert property (write_busy |-> busy_n < WR_CYCLES)
    else $error("write cycle too long");
  a_busy_min: assert property ($fell(write_busy) |-> busy_n >= WR_CYCLES - 8)
    else $error("write cycle ended early");
  a_ack_count: assert property (s_word_ack |-> rises == 4'h8)
    else $error("device word acknowledge not on the ninth clock");
  a_ack_match: assert property (s_word_ack |-> word[7:4] == DEV_TYPE &&
    word[3:1] == {select_pin_high, select_pin_mid, select_pin_low})
    else $error("device word acknowledged without a match");
endmodule

// ### verif/test_serial_eeprom_rw_engine.sv
// bench: controller and eeprom engine joined over the two-wire link
`timescale 1ns/100ps
module test_serial_eeprom_rw_engine;
  import sere_pkg::*;
  localparam int         WRC = 1500;  // short self-timed write
  localparam logic [2:0] SEL = 3'h5;  // strap of the select pins
  logic        clock      = 1'b0;
  logic        rstn       = 1'b0;
  logic        cmd_valid  = 1'b0;
  logic        cmd_nack   = 1'b0;
  logic [7:0]  cmd_data   = 8'h00;
  logic [2:0]  strap      = SEL;
  sere_op_t    cmd_op     = OP_START;
  logic        cmd_ready, rsp_valid, rsp_ack, write_busy;
  logic [7:0]  rsp_data;
  logic [15:0] rows [3]   = '{16'h003c, 16'h01a5, 16'h5ac3};  // address, data
  int          n_mismatch = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          tries;

  sere_link_if link ();
  sere_dev #(.BIG(1'b0), .WR_CYCLES(WRC)) u_sere_dev (.clock(clock), .rstn(rstn), .link(link.dev),
    .select_pin_high(strap[2]), .select_pin_mid(strap[1]), .select_pin_low(strap[0]), .write_busy(write_busy));
  sere_host u_sere_host (.clock(clock), .rstn(rstn), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  sere_props #(.WR_CYCLES(WRC)) chk (.clock(clock), .rstn(rstn), .scl(link.scl), .sda(link.sda),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe), .write_busy(write_busy),
    .select_pin_high(strap[2]), .select_pin_mid(strap[1]), .select_pin_low(strap[0]));

  // core clock
  always #12.5 clock = ~clock;

  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one controller command, held for one clock, then wait for idle
  task automatic op(sere_op_t o, logic [7:0] d = 8'h00, logic nk = 1'b0);
    int n;
    n = 0;
    cmd_op = o;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(posedge clock);
      #1 n++;
    end
    check({7'h0, rsp_valid}, {7'h0, o == OP_WRITE || o == OP_READ});
  endtask

  task automatic wr(logic [7:0] d, logic a);
    op(OP_WRITE, d);
    check({7'h0, rsp_ack}, {7'h0, a});
  endtask

  task automatic rd(logic nk, logic [7:0] e);
    op(OP_READ, 8'h00, nk);
    check(rsp_data, e);
  endtask

  // start plus device word until acknowledged, counting tries
  task automatic poll(logic rw, logic [7:0] n);
    tries = 0;
    do begin
      op(OP_START);
      op(OP_WRITE, {DEV_TYPE, SEL, rw});
      tries++;
    end while (rsp_ack !== 1'b1 && tries < 8);
    check(8'(tries), n);
  endtask

  // dummy write of the word address, then restart for reading
  task automatic seek(logic [7:0] a, logic [7:0] n);
    poll(1'b0, n);
    wr(a, 1'b1);
    op(OP_START);
    wr({DEV_TYPE, SEL, 1'b1}, 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    check({4'h0, cmd_ready, link.scl, link.sda, write_busy}, 8'h0e);
    // byte write then random read back, one row each
    foreach (rows[i]) begin
      poll(1'b0, 8'h01);
      wr(rows[i][15:8], 1'b1);
      wr(rows[i][7:0], 1'b1);
      op(OP_STOP);
      check({7'h0, write_busy}, 8'h01);
      seek(rows[i][15:8], 8'h02);
      rd(1'b1, rows[i][7:0]);
      op(OP_STOP);
    end
    // page write of ten bytes from mid page wraps and overwrites
    poll(1'b0, 8'h01);
    wr(8'h16, 1'b1);
    for (int i = 0; i < 10; i++)
      wr(8'h80 + 8'(i), 1'b1);
    op(OP_STOP);
    poll(1'b1, 8'h02);
    rd(1'b1, 8'h82);
    op(OP_STOP);
    seek(8'h11, 8'h01);
    for (int k = 1; k < 8; k++)
      rd(k == 7, 8'h82 + 8'(k));
    op(OP_STOP);
    // sequential read across the top of the array
    seek(8'hfe, 8'h01);
    rd(1'b0, ERASED);
    rd(1'b0, ERASED);
    rd(1'b1, 8'h3c);
    op(OP_STOP);
    op(OP_START);
    wr({DEV_TYPE, SEL, 1'b1}, 1'b1);
    rd(1'b1, 8'ha5);
    op(OP_STOP);
    // wrong select and wrong type are refused
    op(OP_START);
    wr({DEV_TYPE, SEL ^ 3'h1, 1'b0}, 1'b0);
    op(OP_START);
    wr({DEV_TYPE ^ 4'h8, SEL, 1'b0}, 1'b0);
    op(OP_STOP);
    check({6'h0, write_busy, link.sda}, 8'h01);
    // other strap: the new select bits match, the old ones no longer do
    strap = SEL ^ 3'h2;
    op(OP_START);
    wr({DEV_TYPE, SEL, 1'b0}, 1'b0);
    op(OP_START);
    wr({DEV_TYPE, SEL ^ 3'h2, 1'b0}, 1'b1);
    op(OP_STOP);
    strap = SEL;
    // reset in mid-run: link idle, array erased, counter back to zero
    @(posedge clock);
    #1 rstn = 1'b0;
    @(posedge clock);
    #1 check({4'h0, cmd_ready, link.scl, link.sda, write_busy}, 8'h0e);
    @(posedge clock);
    #1 rstn = 1'b1;
    op(OP_START);
    wr({DEV_TYPE, SEL, 1'b1}, 1'b1);
    rd(1'b1, ERASED);
    op(OP_STOP);
    stop_test();
  end
endmodule
